// file: rtl/lsc_limit_out.sv
// lsc_limit_out: limit switch outputs driven from watch values against two ON ranges
// assumes motion_data comes from logic on aclk; controller_ready_flag is an async pin
//
// Function
// R1: target bit follows watch-versus-range comparison
// R2: two independent ON ranges per entry
// R3: point-wise updates, or 16-bit batch writes
// R4: unassigned bits of a batch group stay off
// R5: compensation clamped to plus/minus five seconds
// R6: positive compensation advances the switching instant
// R7: watch source: motion, word, ring counter
// R8: master picks width; 32-bit words at even index
// R9: ring wrap value configured and used
// R10: limits share the watch value's width
// R11: limits are constants or memory words
// R12: motion quantities compared at their own widths
// R13: indirect compensation pair starts at even index
// R14: physical inputs refused; reserved inputs stay zero
// R15: force-on beats force-off
// R16: ready fall clears outputs unless keep allows
// R17: inclusive ranges checked once per operation cycle
`timescale 1ns/10ps
module lsc_limit_out #(
	parameter int NUM_ENT     = 64,
	parameter int TGT_BITS    = 256,
	parameter int WORD_DEPTH  = 64,
	parameter int NUM_AXES    = 32,
	parameter int NUM_QTY     = 18,
	parameter int OP_CYCLE_US = 1000
) (
	input  wire logic                             aclk,
	input  wire logic                             aresetn,
	input  wire lsc_pkg::lsc_axil_req_t           axil_req,
	output      lsc_pkg::lsc_axil_rsp_t           axil_rsp,
	input  wire logic [NUM_AXES*NUM_QTY*32-1:0]   motion_data,
	input  wire logic                             controller_ready_flag,
	output      logic [TGT_BITS-1:0]              target_bits
);
	import lsc_pkg::*;

	localparam int NGRP    = TGT_BITS / GRP_W;
	localparam int OP_CYC  = OP_CYCLE_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int OPC_W   = $clog2(OP_CYC + 1);
	localparam int EIX_W   = $clog2(NUM_ENT);
	localparam int ENT_END = int'(ENT_BASE) + (NUM_ENT << ENT_SH);
	localparam int WRD_END = int'(WORD_BASE) + (WORD_DEPTH << WORD_SH);
	localparam int IMG_END = int'(IMG_BASE) + (NGRP << WORD_SH);

	// bus and register state
	logic                    aw_held_ff, nxt_aw_held, w_held_ff, nxt_w_held;
	logic [15:0]             aw_addr_ff, nxt_aw_addr, ar_addr_ff, nxt_ar_addr;
	logic [31:0]             w_data_ff, nxt_w_data;
	logic [3:0]              w_strb_ff, nxt_w_strb;
	logic                    ar_held_ff, nxt_ar_held;
	lsc_axil_rsp_t           rsp_ff, nxt_rsp;
	logic                    keep_ff, nxt_keep;
	logic [NGRP-1:0]         phys_in_ff, nxt_phys_in, phys_out_ff, nxt_phys_out;
	logic [31:0]             ent_ff [NUM_ENT][EW_NUM];
	logic [31:0]             nxt_ent [NUM_ENT][EW_NUM];
	logic [15:0]             wmem_ff [WORD_DEPTH];
	logic [15:0]             nxt_wmem [WORD_DEPTH];
	logic [31:0]             rd_data;
	logic                    rd_ok, wr_ok;
	int                      wa, ra;

	// scan state
	lsc_state_t              st_ff, nxt_st;
	logic [EIX_W-1:0]        idx_ff, nxt_idx;
	logic [OPC_W-1:0]        opc_ff, nxt_opc;
	logic [TGT_BITS-1:0]     img_ff, nxt_img, acc_ff, nxt_acc;
	logic [NGRP-1:0]         touch_ff, nxt_touch;
	logic [31:0]             prev_ff [NUM_ENT];
	logic [31:0]             nxt_prev [NUM_ENT];
	logic                    rs1_ff, rs2_ff, rs3_ff, rdy_ff, nxt_rdy, rdy_old_ff;

	// entry evaluation terms
	logic [31:0]             ctrl, tgtw, raw, ring;
	logic [1:0]              src;
	logic [4:0]              qty;
	logic [7:0]              sidx, tgt;
	logic                    w32, ring_on, on_val, blocked;
	logic signed [63:0]      watch, delta, comp, pred, lo1, hi1, lo2, hi2;

	assign axil_rsp    = rsp_ff;
	assign target_bits = img_ff;

	function automatic logic [31:0] rd_w32(input logic [7:0] i);
		int b;
		b = (int'(i) & ~1) % WORD_DEPTH; // even pairing, low word first R8 R13
		return {wmem_ff[b | 1], wmem_ff[b]};
	endfunction

	function automatic logic signed [63:0] sx(input logic [31:0] r, input logic wide);
		return wide ? {{32{r[31]}}, r} : {{48{r[15]}}, r[15:0]};
	endfunction

	// limit as constant or indirect word, at the watch width
	function automatic logic signed [63:0] lim(input logic [31:0] v, input logic ind,
	                                          input logic wide);
		logic [31:0] r;
		r = v;
		if (ind) begin
			r = wide ? rd_w32(v[7:0]) : {16'h0000, wmem_ff[int'(v[7:0]) % WORD_DEPTH]}; // R11
		end
		return sx(r, wide); // R10
	endfunction

	// bits that may never be driven in a group
	function automatic logic [15:0] illegal(input int g);
		if (phys_in_ff[g]) begin
			return 16'hFFFF;
		end
		return (g == BUILTIN_GRP) ? BUILTIN_RSV : 16'h0000;
	endfunction

	// bus slave and register file
	always_comb begin
		nxt_aw_held  = aw_held_ff;
		nxt_aw_addr  = aw_addr_ff;
		nxt_w_held   = w_held_ff;
		nxt_w_data   = w_data_ff;
		nxt_w_strb   = w_strb_ff;
		nxt_ar_held  = ar_held_ff;
		nxt_ar_addr  = ar_addr_ff;
		nxt_rsp      = rsp_ff;
		nxt_keep     = keep_ff;
		nxt_phys_in  = phys_in_ff;
		nxt_phys_out = phys_out_ff;
		nxt_ent      = ent_ff;
		nxt_wmem     = wmem_ff;
		rd_data      = 32'h0000_0000;
		rd_ok        = 1'b1;
		wr_ok        = 1'b1;
		wa           = int'(aw_addr_ff);
		ra           = int'(ar_addr_ff);
		if (axil_req.awvalid && rsp_ff.awready) begin
			nxt_aw_held = 1'b1;
			nxt_aw_addr = axil_req.awaddr;
		end
		if (axil_req.wvalid && rsp_ff.wready) begin
			nxt_w_held = 1'b1;
			nxt_w_data = axil_req.wdata;
			nxt_w_strb = axil_req.wstrb;
		end
		// write once both halves are held and no response is pending
		if (aw_held_ff && w_held_ff && !rsp_ff.bvalid) begin
			if (wa == int'(REG_CFG)) begin
				if (w_strb_ff[0]) nxt_keep = w_data_ff[CFG_KEEP];
			end else if (wa == int'(REG_PHYS_IN)) begin
				for (int b = 0; b < NGRP; b++) if (w_strb_ff[b/8]) nxt_phys_in[b] = w_data_ff[b];
			end else if (wa == int'(REG_PHYS_OUT)) begin
				for (int b = 0; b < NGRP; b++) if (w_strb_ff[b/8]) nxt_phys_out[b] = w_data_ff[b];
			end else if (wa >= int'(ENT_BASE) && wa < ENT_END) begin
				for (int b = 0; b < 4; b++) begin
					if (w_strb_ff[b]) begin
						nxt_ent[(wa - int'(ENT_BASE)) >> ENT_SH][(wa >> 2) % EW_NUM][b*8 +: 8] =
							w_data_ff[b*8 +: 8];
					end
				end
			end else if (wa >= int'(WORD_BASE) && wa < WRD_END) begin
				for (int b = 0; b < 2; b++) begin
					if (w_strb_ff[b]) begin
						nxt_wmem[(wa - int'(WORD_BASE)) >> WORD_SH][b*8 +: 8] = w_data_ff[b*8 +: 8];
					end
				end
			end else begin
				wr_ok = 1'b0;
			end
			nxt_aw_held   = 1'b0;
			nxt_w_held    = 1'b0;
			nxt_rsp.bvalid = 1'b1;
			nxt_rsp.bresp  = wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rsp_ff.bvalid && axil_req.bready) begin
			nxt_rsp.bvalid = 1'b0;
		end
		// read decode of the held address
		if (ra == int'(REG_CFG)) begin
			rd_data[CFG_KEEP] = keep_ff;
		end else if (ra == int'(REG_STATUS)) begin
			rd_data[STS_READY] = rdy_ff;
			rd_data[STS_BUSY]  = (st_ff != ST_IDLE);
		end else if (ra == int'(REG_PHYS_IN)) begin
			rd_data[NGRP-1:0] = phys_in_ff;
		end else if (ra == int'(REG_PHYS_OUT)) begin
			rd_data[NGRP-1:0] = phys_out_ff;
		end else if (ra >= int'(IMG_BASE) && ra < IMG_END) begin
			rd_data[GRP_W-1:0] = img_ff[((ra - int'(IMG_BASE)) >> WORD_SH) * GRP_W +: GRP_W];
		end else if (ra >= int'(ENT_BASE) && ra < ENT_END) begin
			rd_data = ent_ff[(ra - int'(ENT_BASE)) >> ENT_SH][(ra >> 2) % EW_NUM];
		end else if (ra >= int'(WORD_BASE) && ra < WRD_END) begin
			rd_data[15:0] = wmem_ff[(ra - int'(WORD_BASE)) >> WORD_SH];
		end else begin
			rd_ok = 1'b0;
		end
		if (ar_held_ff && !rsp_ff.rvalid) begin
			nxt_ar_held   = 1'b0;
			nxt_rsp.rvalid = 1'b1;
			nxt_rsp.rdata  = rd_data;
			nxt_rsp.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rsp_ff.rvalid && axil_req.rready) begin
			nxt_rsp.rvalid = 1'b0;
		end
		if (axil_req.arvalid && rsp_ff.arready) begin
			nxt_ar_held = 1'b1;
			nxt_ar_addr = axil_req.araddr;
		end
		// ready flags depend on what is held, one address each; arready also waits for a pending read answer
		nxt_rsp.awready = !nxt_aw_held;
		nxt_rsp.wready  = !nxt_w_held;
		nxt_rsp.arready = !nxt_ar_held && !nxt_rsp.rvalid;
	end

	// evaluation of the entry under the scan index
	always_comb begin
		ctrl = ent_ff[idx_ff][EW_CTRL];
		tgtw = ent_ff[idx_ff][EW_TGT];
		src  = ctrl[CB_SRC_LSB +: 2];
		qty  = ctrl[CB_QTY_LSB +: 5];
		sidx = tgtw[TF_IDX_LSB +: 8];
		tgt  = tgtw[7:0];
		raw  = 32'h0000_0000;
		if (src == SRC_MOTION) begin
			w32 = !(qty == QTY_MULTI_REV || qty == QTY_DEVIATION || qty == QTY_MOTOR_CUR); // R12
			if (int'(sidx) < NUM_AXES && int'(qty) < NUM_QTY) begin
				raw = motion_data[(int'(sidx) * NUM_QTY + int'(qty)) * 32 +: 32]; // R7
			end
		end else begin
			w32 = ctrl[CB_W32]; // R8
			raw = w32 ? rd_w32(sidx) : {16'h0000, wmem_ff[int'(sidx) % WORD_DEPTH]}; // R7
		end
		watch = sx(raw, w32);
		lo1   = lim(ent_ff[idx_ff][EW_LO1], ctrl[CB_LO1_IND], w32);
		hi1   = lim(ent_ff[idx_ff][EW_HI1], ctrl[CB_HI1_IND], w32);
		lo2   = lim(ent_ff[idx_ff][EW_LO2], ctrl[CB_LO2_IND], w32);
		hi2   = lim(ent_ff[idx_ff][EW_HI2], ctrl[CB_HI2_IND], w32);
		// compensation, saturated
		comp = sx(ctrl[CB_COMP_IND] ? rd_w32(ent_ff[idx_ff][EW_COMP][7:0])
		                           : ent_ff[idx_ff][EW_COMP], 1'b1);
		if (comp < COMP_MIN_US) comp = COMP_MIN_US; // R5
		if (comp > COMP_MAX_US) comp = COMP_MAX_US; // R5
		// ring wrap value, held inside the 16-bit range when narrow
		ring = ent_ff[idx_ff][EW_RING];
		if (!w32 && ring > RING16_MAX) ring = RING16_MAX;
		ring_on = (src == SRC_RING) && (ring != 32'h0000_0000) && !ring[31]; // R9
		// speed per operation cycle; across a wrap take the short way round
		delta = watch - sx(prev_ff[idx_ff], 1'b1);
		if (ring_on) begin
			if (delta > $signed({32'h0000_0000, ring >> 1})) delta = delta - $signed({32'h0, ring}); // R9
			else if (-delta > $signed({32'h0000_0000, ring >> 1})) delta = delta + $signed({32'h0, ring});
		end
		// predict where the value will be after the compensation time
		pred = watch + (delta * comp) / OP_CYCLE_US; // R6
		if (ring_on) begin
			pred = pred % $signed({32'h0000_0000, ring}); // R9
			if (pred < 0) pred = pred + $signed({32'h0000_0000, ring});
		end
		on_val = (pred >= lo1 && pred <= hi1) || // R2 R17
		         (ctrl[CB_R2_EN] && pred >= lo2 && pred <= hi2); // R2 R17
		if (ctrl[CB_FON_EN] && ctrl[CB_FON]) on_val = 1'b1; // R15
		else if (ctrl[CB_FOFF_EN] && ctrl[CB_FOFF]) on_val = 1'b0; // R15
		blocked = phys_in_ff[int'(tgt) / GRP_W] || int'(tgt) >= TGT_BITS || // R14
		          (int'(tgt) / GRP_W == BUILTIN_GRP && BUILTIN_RSV[int'(tgt) % GRP_W]); // R14
	end

	// scan sequencer, operation cycle timer and ready flag handling
	always_comb begin
		nxt_st    = st_ff;
		nxt_idx   = idx_ff;
		nxt_img   = img_ff;
		nxt_acc   = acc_ff;
		nxt_touch = touch_ff;
		nxt_prev  = prev_ff;
		nxt_opc   = (int'(opc_ff) == OP_CYC - 1) ? '0 : opc_ff + 1'b1;
		// a change counts only once the two late stages agree
		nxt_rdy   = (rs2_ff == rs3_ff) ? rs3_ff : rdy_ff;
		case (st_ff)
			ST_IDLE: begin
				if (int'(opc_ff) == OP_CYC - 1 && rdy_ff) begin // R17
					nxt_st    = ST_EVAL;
					nxt_idx   = '0;
					nxt_acc   = '0; // R4
					nxt_touch = '0;
				end
			end
			ST_EVAL: begin
				if (ctrl[CB_EN]) begin
					nxt_prev[idx_ff] = watch[31:0];
					if (!blocked) begin // R14
						if (ctrl[CB_BATCH]) begin
							nxt_acc[tgt] = on_val; // R3
							nxt_touch[int'(tgt) / GRP_W] = 1'b1;
						end else begin
							nxt_img[tgt] = on_val; // R1 R3
						end
					end
				end
				if (int'(idx_ff) == NUM_ENT - 1) begin
					nxt_st = ST_FLUSH;
				end else begin
					nxt_idx = idx_ff + 1'b1;
				end
			end
			ST_FLUSH: begin
				// whole groups at once, unassigned bits cleared
				for (int g = 0; g < NGRP; g++) begin
					if (touch_ff[g]) nxt_img[g*GRP_W +: GRP_W] = acc_ff[g*GRP_W +: GRP_W]; // R3 R4
				end
				nxt_st = ST_IDLE;
			end
			default: begin
				nxt_st = ST_IDLE;
			end
		endcase
		// ready falling: abort scan, clear what may not be kept
		if (rdy_old_ff && !rdy_ff) begin
			nxt_st = ST_IDLE;
			for (int g = 0; g < NGRP; g++) begin
				if (!keep_ff || phys_out_ff[g]) nxt_img[g*GRP_W +: GRP_W] = '0; // R16
			end
		end
		// refused and reserved input bits never read back as set
		for (int g = 0; g < NGRP; g++) begin
			nxt_img[g*GRP_W +: GRP_W] = nxt_img[g*GRP_W +: GRP_W] & ~illegal(g); // R14
		end
	end

	// registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff  <= 1'b0;
			aw_addr_ff  <= '0;
			w_held_ff   <= 1'b0;
			w_data_ff   <= '0;
			w_strb_ff   <= '0;
			ar_held_ff  <= 1'b0;
			ar_addr_ff  <= '0;
			rsp_ff      <= '0;
			keep_ff     <= 1'b0;
			phys_in_ff  <= '0;
			phys_out_ff <= '0;
			st_ff       <= ST_IDLE;
			idx_ff      <= '0;
			opc_ff      <= '0;
			img_ff      <= '0;
			acc_ff      <= '0;
			touch_ff    <= '0;
			rs1_ff      <= 1'b0;
			rs2_ff      <= 1'b0;
			rs3_ff      <= 1'b0;
			rdy_ff      <= 1'b0;
			rdy_old_ff  <= 1'b0;
			for (int e = 0; e < NUM_ENT; e++) begin
				prev_ff[e] <= '0;
				for (int k = 0; k < EW_NUM; k++) ent_ff[e][k] <= '0;
			end
			for (int i = 0; i < WORD_DEPTH; i++) wmem_ff[i] <= '0;
		end else begin
			aw_held_ff  <= nxt_aw_held;
			aw_addr_ff  <= nxt_aw_addr;
			w_held_ff   <= nxt_w_held;
			w_data_ff   <= nxt_w_data;
			w_strb_ff   <= nxt_w_strb;
			ar_held_ff  <= nxt_ar_held;
			ar_addr_ff  <= nxt_ar_addr;
			rsp_ff      <= nxt_rsp;
			keep_ff     <= nxt_keep;
			phys_in_ff  <= nxt_phys_in;
			phys_out_ff <= nxt_phys_out;
			st_ff       <= nxt_st;
			idx_ff      <= nxt_idx;
			opc_ff      <= nxt_opc;
			img_ff      <= nxt_img;
			acc_ff      <= nxt_acc;
			touch_ff    <= nxt_touch;
			rs1_ff      <= controller_ready_flag;
			rs2_ff      <= rs1_ff;
			rs3_ff      <= rs2_ff;
			rdy_ff      <= nxt_rdy;
			rdy_old_ff  <= rdy_ff;
			prev_ff     <= nxt_prev;
			ent_ff      <= nxt_ent;
			wmem_ff     <= nxt_wmem;
		end
	end

endmodule

// file: rtl/lsc_pkg.sv
// lsc_pkg: constants, bus carriers and scan states of the limit switch output block
// assumes a 40 MHz aclk and an AXI4-Lite master with 16-bit byte addresses
package lsc_pkg;

	// bus carriers, master to slave and slave to master
	typedef struct packed {
		logic        awvalid;
		logic [15:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [15:0] araddr;
		logic        rready;
	} lsc_axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} lsc_axil_rsp_t;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// register map, byte addresses
	localparam logic [15:0] REG_CFG      = 16'h0000;
	localparam logic [15:0] REG_STATUS   = 16'h0004;
	localparam logic [15:0] REG_PHYS_IN  = 16'h0008;
	localparam logic [15:0] REG_PHYS_OUT = 16'h000C;
	localparam logic [15:0] IMG_BASE     = 16'h0040;
	localparam logic [15:0] ENT_BASE     = 16'h0400;
	localparam logic [15:0] WORD_BASE    = 16'h0C00;
	localparam int          ENT_SH       = 5;
	localparam int          WORD_SH      = 2;

	// words inside one entry
	localparam int EW_CTRL = 0;
	localparam int EW_TGT  = 1;
	localparam int EW_COMP = 2;
	localparam int EW_RING = 3;
	localparam int EW_LO1  = 4;
	localparam int EW_HI1  = 5;
	localparam int EW_LO2  = 6;
	localparam int EW_HI2  = 7;
	localparam int EW_NUM  = 8;

	// entry control and target word fields, then config and status register bits
	localparam int CB_EN       = 0;
	localparam int CB_SRC_LSB  = 1;
	localparam int CB_W32      = 3;
	localparam int CB_BATCH    = 4;
	localparam int CB_FOFF_EN  = 5;
	localparam int CB_FON_EN   = 6;
	localparam int CB_FOFF     = 7;
	localparam int CB_FON      = 8;
	localparam int CB_LO1_IND  = 9;
	localparam int CB_HI1_IND  = 10;
	localparam int CB_LO2_IND  = 11;
	localparam int CB_HI2_IND  = 12;
	localparam int CB_COMP_IND = 13;
	localparam int CB_R2_EN    = 14;
	localparam int CB_QTY_LSB  = 16;
	localparam int TF_IDX_LSB  = 8;
	localparam int CFG_KEEP    = 0;
	localparam int STS_READY   = 0;
	localparam int STS_BUSY    = 1;

	// watch source kinds and the motion quantities compared as 16-bit
	localparam logic [1:0] SRC_MOTION    = 2'h0;
	localparam logic [1:0] SRC_WORD      = 2'h1;
	localparam logic [1:0] SRC_RING      = 2'h2;
	localparam logic [4:0] QTY_MULTI_REV = 5'h06;
	localparam logic [4:0] QTY_DEVIATION = 5'h07;
	localparam logic [4:0] QTY_MOTOR_CUR = 5'h0A;

	// compensation clamp, ring limit, target groups
	localparam logic signed [63:0] COMP_MAX_US = 64'sd5000000;
	localparam logic signed [63:0] COMP_MIN_US = -64'sd5000000;
	localparam logic [31:0]        RING16_MAX  = 32'h0000_7FFF;
	localparam int                 GRP_W       = 16;
	localparam int                 BUILTIN_GRP = 0;
	localparam logic [15:0]        BUILTIN_RSV = 16'hFFF0;

	// timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int NS_PER_US     = 1000;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_EVAL  = 3'h2,
		ST_FLUSH = 3'h4
	} lsc_state_t;

endpackage

// file: verif/lsc_far_model.sv
// lsc_far_model: far side of the limit block, motion words and the ready pin
// assumes the bench loads one motion word per aclk edge through set_en
`timescale 1ns/10ps
module lsc_far_model #(
	parameter int NW = 1152
) (
	input  wire logic          aclk,
	input  wire logic          set_en,
	input  wire logic [6:0]    set_idx,
	input  wire logic [31:0]   set_val,
	input  wire logic          ready_req,
	output      logic [NW-1:0] motion_data,
	output      logic          controller_ready_flag
);
	// servo side publishes each quantity on aclk, no glitches between edges
	initial motion_data = '0;
	always @(posedge aclk) begin
		if (set_en) begin
			motion_data[set_idx*32+:32] <= set_val;
		end
	end
	// pin lags off the clock edge so the design's synchroniser really works
	assign #7 controller_ready_flag = ready_req;
endmodule

// file: verif/lsc_limit_out_props.sv
// lsc_limit_out_chk: port-level checks of the limit output block
// assumes the master keeps bready and rready high and offers aw with w
`timescale 1ns/10ps
module lsc_limit_out_chk
	import lsc_pkg::*;
#(
	parameter int TGT_BITS = 256
) (
	input wire logic                   aclk,
	input wire logic                   aresetn,
	input wire lsc_pkg::lsc_axil_req_t axil_req,
	input wire lsc_pkg::lsc_axil_rsp_t axil_rsp,
	input wire logic                   controller_ready_flag,
	input wire logic [TGT_BITS-1:0]    target_bits
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire logic aw_go = axil_req.awvalid && axil_rsp.awready;
	wire logic w_go  = axil_req.wvalid && axil_rsp.wready;
	wire logic ar_go = axil_req.arvalid && axil_rsp.arready;
	logic      keep_ff;
	logic      nxt_keep;
	// mirror of the keep option, so the clear check knows whether groups may hold
	always_comb begin
		nxt_keep = keep_ff;
		if (aw_go && w_go && axil_req.awaddr == REG_CFG) begin
			nxt_keep = axil_req.wdata[CFG_KEEP];
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			keep_ff <= 1'b0;
		end else begin
			keep_ff <= nxt_keep;
		end
	end
	// bus timing and error read data as handed over, reserved bits kept zero; the rest ties outputs to the ready pin
	property p_wr_resp; aw_go && w_go && !axil_rsp.bvalid |-> ##2 axil_rsp.bvalid; endproperty
	property p_rd_resp; ar_go |-> ##2 axil_rsp.rvalid; endproperty
	property p_aw_busy; aw_go |=> !axil_rsp.awready; endproperty
	property p_ar_busy; ar_go |=> !axil_rsp.arready; endproperty
	property p_b_once; axil_rsp.bvalid && axil_req.bready |=> !axil_rsp.bvalid; endproperty
	property p_r_once; axil_rsp.rvalid && axil_req.rready |=> !axil_rsp.rvalid; endproperty
	property p_err_zero;
		axil_rsp.rvalid && axil_rsp.rresp == RESP_SLVERR |-> axil_rsp.rdata == '0;
	endproperty
	property p_rsv_zero; (target_bits[15:0] & BUILTIN_RSV) == '0; endproperty
	property p_clear; (!controller_ready_flag && !keep_ff) [*8] |-> target_bits == '0; endproperty
	property p_hold; !controller_ready_flag [*8] |=> $stable(target_bits); endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
	a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
	a_aw_busy: assert property (p_aw_busy) else $error("awready stayed high");
	a_ar_busy: assert property (p_ar_busy) else $error("arready stayed high");
	a_b_once: assert property (p_b_once) else $error("bvalid not dropped");
	a_r_once: assert property (p_r_once) else $error("rvalid not dropped");
	a_err_zero: assert property (p_err_zero) else $error("error read not zero");
	a_rsv_zero: assert property (p_rsv_zero) else $error("reserved input set");
	a_clear: assert property (p_clear) else $error("outputs not cleared");
	a_hold: assert property (p_hold) else $error("outputs moved while not ready");
	c_wr: cover property (aw_go && w_go);
	c_err: cover property (axil_rsp.rvalid && axil_rsp.rresp == RESP_SLVERR);
	c_keep: cover property (!controller_ready_flag && keep_ff);
endmodule
bind lsc_limit_out lsc_limit_out_chk #(.TGT_BITS(TGT_BITS)) u_chk (
	.aclk(aclk), .aresetn(aresetn), .axil_req(axil_req), .axil_rsp(axil_rsp),
	.controller_ready_flag(controller_ready_flag), .target_bits(target_bits)
);

// file: verif/tb.sv
// tb: self-checking bench of the limit output block over AXI4-Lite
// assumes lsc_far_model drives motion words and the ready pin
`timescale 1ns/10ps
module tb;
	import lsc_pkg::*;
	localparam int NA = 2;
	localparam int NQ = 18;
	localparam int OPUS = 1;
	localparam int WT = 2 * OPUS * NS_PER_US / CLK_PERIOD_NS + 10;
	typedef struct packed {
		logic [15:0] tgt;
		logic [23:0] ctrl;
		logic [23:0] watch;
		logic [23:0] lo1;
		logic [23:0] hi1;
		logic [7:0]  ring;
		logic [7:0]  lo2;
		logic [7:0]  hi2;
		logic        ex;
	} lsc_row_t;
	logic               aclk;
	logic               aresetn;
	lsc_axil_req_t      req;
	lsc_axil_rsp_t      rsp;
	logic [NA*NQ*32-1:0] motion_data;
	logic               flag;
	logic [255:0]       target_bits;
	logic               set_en;
	logic [6:0]         set_idx;
	logic [31:0]        set_val;
	logic               ready_req;
	logic [31:0]        d;
	logic [1:0]         rs;
	int                 n_mismatch = 0;
	int                 samples_checked = 0;
	int                 n;
	// target, ctrl, watch, lo1, hi1, ring, lo2, hi2, expected bit
	lsc_row_t rows[12] = '{
		'{16'h0014, 24'h00_0003, 24'h00_000A, 24'h00_000A, 24'h00_0014, 8'h00, 8'h00, 8'h00, 1'b1},
		'{16'h0014, 24'h00_0003, 24'h00_0023, 24'h00_000A, 24'h00_0014, 8'h00, 8'h1E, 8'h28, 1'b0},
		'{16'h0014, 24'h00_0403, 24'h00_0014, 24'h00_000A, 24'h00_0000, 8'h00, 8'h00, 8'h00, 1'b1},
		'{16'h0014, 24'h00_4003, 24'h00_0023, 24'h00_000A, 24'h00_0014, 8'h00, 8'h1E, 8'h28, 1'b1},
		'{16'h0014, 24'h00_00A3, 24'h00_000A, 24'h00_000A, 24'h00_0014, 8'h00, 8'h00, 8'h00, 1'b0},
		'{16'h0014, 24'h00_01E3, 24'h00_0000, 24'h00_000A, 24'h00_0014, 8'h00, 8'h00, 8'h00, 1'b1},
		'{16'h0014, 24'h00_0003, 24'h00_FFFE, 24'h00_FFFB, 24'h00_0005, 8'h00, 8'h00, 8'h00, 1'b1},
		'{16'h0032, 24'h00_0003, 24'h00_000A, 24'h00_000A, 24'h00_0014, 8'h00, 8'h00, 8'h00, 1'b0},
		'{16'h0114, 24'h00_0001, 24'h01_0000, 24'h00_FFFF, 24'h01_0000, 8'h00, 8'h00, 8'h00, 1'b1},
		'{16'h0114, 24'h06_0001, 24'h01_0005, 24'h00_0000, 24'h00_000A, 8'h00, 8'h00, 8'h00, 1'b1},
		'{16'h0014, 24'h00_0005, 24'h00_0096, 24'h00_0028, 24'h00_003C, 8'h64, 8'h00, 8'h00, 1'b1},
		'{16'h0214, 24'h00_000B, 24'hFF_FFFF, 24'h01_0000, 24'hFF_FFFF, 8'h00, 8'h00, 8'h00, 1'b1}
	};
	lsc_limit_out #(.NUM_ENT(4), .NUM_AXES(NA), .NUM_QTY(NQ), .OP_CYCLE_US(OPUS)) u_dut (
		.aclk(aclk), .aresetn(aresetn), .axil_req(req), .axil_rsp(rsp),
		.motion_data(motion_data), .controller_ready_flag(flag), .target_bits(target_bits)
	);
	lsc_far_model #(.NW(NA*NQ*32)) u_far (
		.aclk(aclk), .set_en(set_en), .set_idx(set_idx), .set_val(set_val),
		.ready_req(ready_req), .motion_data(motion_data), .controller_ready_flag(flag)
	);
	// 40 MHz clock
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	task automatic tally_and_finish();
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic cmp_w(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_b(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t bit %b expected %b", $time, got, exp);
		end
	endtask
	function automatic logic [15:0] ea(input int e, input int k);
		return ENT_BASE + 16'((e << ENT_SH) + (k << WORD_SH));
	endfunction
	function automatic logic [15:0] wa(input int i);
		return WORD_BASE + 16'(i << WORD_SH);
	endfunction
	// aw and w offered together, each dropped when taken; bready stays high
	task automatic axw(input logic [15:0] a, input logic [31:0] v, output logic [1:0] r);
		logic aw = 1'b0, w = 1'b0;
		req.awaddr <= a;
		req.wdata <= v;
		req.wstrb <= 4'hF;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			aw = aw | rsp.awready;
			w = w | rsp.wready;
			if (aw) req.awvalid <= 1'b0;
			if (w) req.wvalid <= 1'b0;
		end while (!(aw && w));
		do @(posedge aclk); while (!rsp.bvalid);
		r = rsp.bresp;
	endtask
	task automatic axr(input logic [15:0] a, output logic [31:0] v, output logic [1:0] r);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		do @(posedge aclk); while (!rsp.arready);
		req.arvalid <= 1'b0;
		do @(posedge aclk); while (!rsp.rvalid);
		v = rsp.rdata;
		r = rsp.rresp;
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] v);
		logic [1:0] r;
		axw(a, v, r);
		cmp_w({30'h0, r}, 32'h0000_0000);
	endtask
	// entry disabled first so a new target never inherits the old one
	task automatic ent(input int e, input lsc_row_t r);
		wr(ea(e, EW_CTRL), 32'h0000_0000);
		wr(ea(e, EW_TGT), {16'h0000, r.tgt});
		wr(ea(e, EW_RING), {24'h00_0000, r.ring});
		wr(ea(e, EW_LO1), {8'h00, r.lo1});
		wr(ea(e, EW_HI1), {8'h00, r.hi1});
		wr(ea(e, EW_LO2), {24'h00_0000, r.lo2});
		wr(ea(e, EW_HI2), {24'h00_0000, r.hi2});
		wr(ea(e, EW_CTRL), {8'h00, r.ctrl});
		repeat (WT) @(posedge aclk);
	endtask
	// a hung handshake ends the run here
	initial begin
		repeat (30000) @(posedge aclk);
		n_mismatch++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		req = '0;
		req.bready = 1'b1;
		req.rready = 1'b1;
		aresetn = 1'b0;
		ready_req = 1'b0;
		set_en = 1'b0;
		set_idx = 7'h00;
		set_val = 32'h0000_0000;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		cmp_b(|target_bits, 1'b0);
		axr(REG_CFG, d, rs);
		cmp_w(d, 32'h0000_0000);
		axr(16'h0010, d, rs);
		cmp_w({30'h0, rs}, {30'h0, RESP_SLVERR});
		axw(16'h0010, 32'h0000_FFFF, rs);
		cmp_w({30'h0, rs}, {30'h0, RESP_SLVERR});
		ready_req <= 1'b1;
		wr(REG_PHYS_IN, 32'h0000_0008);
		foreach (rows[i]) begin
			if (rows[i].ctrl[2:1] == SRC_MOTION) begin
				set_idx <= 7'(rows[i].tgt[15:8] * NQ + rows[i].ctrl[20:16]);
				set_val <= {8'h00, rows[i].watch};
				set_en <= 1'b1;
				@(posedge aclk);
				set_en <= 1'b0;
			end else begin
				wr(wa(rows[i].tgt[15:8]), {16'h0000, rows[i].watch[15:0]});
				wr(wa(rows[i].tgt[15:8] + 1), {24'h00_0000, rows[i].watch[23:16]});
			end
			ent(0, rows[i]);
			cmp_b(target_bits[rows[i].tgt[7:0]], rows[i].ex);
		end
		// point entry lights bit 34, then a batch entry owns its group
		wr(wa(0), 32'h0000_0005);
		ent(0, '{16'h0014, 24'h00_0003, 24'h0, 24'h0, 24'h00_000A, 8'h0, 8'h0, 8'h0, 1'b1});
		ent(2, '{16'h0022, 24'h00_0003, 24'h0, 24'h0, 24'h00_000A, 8'h0, 8'h0, 8'h0, 1'b1});
		cmp_b(target_bits[34], 1'b1);
		wr(ea(2, EW_CTRL), 32'h0000_0000);
		ent(1, '{16'h0021, 24'h00_0013, 24'h0, 24'h0, 24'h00_000A, 8'h0, 8'h0, 8'h0, 1'b1});
		cmp_w({16'h0000, target_bits[47:32]}, 32'h0000_0002);
		axr(IMG_BASE + 16'h0008, d, rs);
		cmp_w(d, 32'h0000_0002);
		// clamped compensation: one count of motion lands five seconds ahead
		wr(wa(4), 32'h0000_03E8);
		wr(wa(5), 32'h0000_0000);
		wr(ea(3, EW_COMP), 32'h0000_0002);
		ent(3, '{16'h0446, 24'h00_200B, 24'h0, 24'h4C_4F29, 24'h4C_4F29, 8'h0, 8'h0, 8'h0, 1'b1});
		cmp_b(target_bits[70], 1'b0);
		wr(wa(4), 32'h0000_03E9);
		n = 0;
		while (target_bits[70] !== 1'b1 && n < WT) begin
			@(posedge aclk);
			n++;
		end
		cmp_b(target_bits[70], 1'b1);
		// ready fall with keep, then without
		wr(REG_CFG, 32'h0000_0001);
		wr(REG_PHYS_OUT, 32'h0000_0004);
		ready_req <= 1'b0;
		repeat (12) @(posedge aclk);
		cmp_b(target_bits[20], 1'b1);
		cmp_b(target_bits[33], 1'b0);
		ready_req <= 1'b1;
		repeat (WT) @(posedge aclk);
		cmp_b(target_bits[33], 1'b1);
		wr(REG_CFG, 32'h0000_0000);
		ready_req <= 1'b0;
		repeat (12) @(posedge aclk);
		cmp_b(|target_bits, 1'b0);
		tally_and_finish();
	end
endmodule
